// ### core/sfre_engine.sv
// Serial flash read engine: array, page, buffer and status reads
`timescale 1ns/1ps

// Contract
// - Array read: 68H/E8H, 24 address, 32 dummy
// - Skip four bits, 11 page, nine byte
// - Read address advances every eight serial clocks
// - Data driven only after the dummy clocks
// - Page end continues at next page byte 0
// - Array end wraps to first page, no gap
// - Chip select rise ends read, floats output
// - Array and page reads leave buffers untouched
// - Burst read shares continuous read sequence
// - Page read: 52H/D2H, address, 32 dummy
// - Page read wraps within the same page
// - Buffer 1 54H/D4H, buffer 2 56H/D6H
// - Buffer read: 15 dummy, nine index, eight dummy
// - Buffer read wraps to buffer byte 0
// - Status read: 57H/D7H, no address follows
// - Status shifted out MSB first, eight clocks
// - Upper five bits info, lower three reserved
// - Status byte repeats with fresh contents
// - Opcode choice sets clock category
// - All link fields travel MSB first
// - Status bit 7 high means ready
module sfre_engine (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sfre_pkg::sfre_load_t load,
  input wire sfre_pkg::sfre_status_t status,
  output logic load_done,
  input wire logic link_sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so_data,
  output logic so_oe_n
);

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] main_mem [sfre_pkg::ARRAY_BYTES];
  logic [7:0] buf1_mem [sfre_pkg::BUF_BYTES];
  logic [7:0] buf2_mem [sfre_pkg::BUF_BYTES];

  // System side
  sfre_pkg::sfre_status_t stat_q;

  // Link side
  logic link_rst_n;
  logic [2:0] en_sync;
  logic en_l;
  sfre_pkg::sfre_status_t stat_s1;
  sfre_pkg::sfre_status_t stat_s2;
  sfre_pkg::sfre_status_t stat_s3;
  sfre_pkg::sfre_status_t stat_l;
  sfre_pkg::sfre_phase_t phase;
  sfre_pkg::sfre_cmd_t cmd;
  sfre_pkg::sfre_cmd_t next_cmd;
  logic [6:0] bit_cnt;
  logic [6:0] data_start;
  logic [6:0] next_start;
  logic [7:0] op_sr;
  logic [7:0] next_op;
  logic [23:0] addr_sr;
  logic [sfre_pkg::PAGE_W-1:0] page_ptr;
  logic [sfre_pkg::BYTE_W-1:0] byte_ptr;
  logic [2:0] bit_idx;
  logic [7:0] stat_byte;
  logic [7:0] stat_shadow;
  logic [7:0] cur_byte;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Linear array index of a page and byte
  function automatic logic [sfre_pkg::LIN_W-1:0] lin_addr(
    input logic [sfre_pkg::PAGE_W-1:0] pg,
    input logic [sfre_pkg::BYTE_W-1:0] by
  );
    logic [31:0] full;
    full = 32'(pg) * 32'(sfre_pkg::PAGE_BYTES) + 32'(by);
    return full[sfre_pkg::LIN_W-1:0];
  endfunction

  // Byte index that lies inside a page or buffer
  function automatic logic in_range(
    input logic [sfre_pkg::BYTE_W-1:0] by
  );
    return by <= sfre_pkg::LAST_BYTE;
  endfunction

  // Opcode decode
  function automatic sfre_pkg::sfre_cmd_t decode(input logic [7:0] op);
    case (op)
      sfre_pkg::OP_ARRAY_LEG, sfre_pkg::OP_ARRAY_SPI: begin
        return sfre_pkg::SFRE_CMD_ARRAY;
      end
      sfre_pkg::OP_PAGE_LEG, sfre_pkg::OP_PAGE_SPI: begin
        return sfre_pkg::SFRE_CMD_PAGE;
      end
      sfre_pkg::OP_BUF1_LEG, sfre_pkg::OP_BUF1_SPI: begin
        return sfre_pkg::SFRE_CMD_BUF1;
      end
      sfre_pkg::OP_BUF2_LEG, sfre_pkg::OP_BUF2_SPI: begin
        return sfre_pkg::SFRE_CMD_BUF2;
      end
      sfre_pkg::OP_STAT_LEG, sfre_pkg::OP_STAT_SPI: begin
        return sfre_pkg::SFRE_CMD_STATUS;
      end
      default: begin
        return sfre_pkg::SFRE_CMD_NONE;
      end
    endcase
  endfunction

  // ---------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------
  // Preload port for array and buffers
  always_ff @(posedge clock) begin
    if (clk_en && load.valid) begin
      case (load.target)
        sfre_pkg::SFRE_TGT_ARRAY: begin
          main_mem[load.addr] <= load.data;
        end
        sfre_pkg::SFRE_TGT_BUF1: begin
          buf1_mem[load.addr[sfre_pkg::BYTE_W-1:0]] <= load.data;
        end
        sfre_pkg::SFRE_TGT_BUF2: begin
          buf2_mem[load.addr[sfre_pkg::BYTE_W-1:0]] <= load.data;
        end
        default: begin
        end
      endcase
    end
  end

  // Load acknowledge pulse
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      load_done <= 1'b0;
    end else if (clk_en) begin
      load_done <= load.valid;
    end
  end

  // Device status held for the link side
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stat_q <= '{ready: sfre_pkg::RST_READY,
                  compare: sfre_pkg::RST_COMPARE};
    end else if (clk_en) begin
      stat_q <= status;
    end
  end

  // ---------------------------------------------------------------
  // Link clock domain
  // ---------------------------------------------------------------
  // Frame reset: deselect clears the whole read path
  assign link_rst_n = reset_n & ~cs_n;

  // Enable and status levels cross into the link domain
  always_ff @(posedge link_sck or negedge reset_n) begin
    if (!reset_n) begin
      en_sync <= {3{sfre_pkg::RST_ENABLE}};
      stat_s1 <= '{ready: sfre_pkg::RST_READY,
                   compare: sfre_pkg::RST_COMPARE};
      stat_s2 <= '{ready: sfre_pkg::RST_READY,
                   compare: sfre_pkg::RST_COMPARE};
      stat_s3 <= '{ready: sfre_pkg::RST_READY,
                   compare: sfre_pkg::RST_COMPARE};
    end else begin
      en_sync <= {en_sync[1:0], clk_en};
      stat_s1 <= stat_q;
      stat_s2 <= stat_s1;
      stat_s3 <= stat_s2;
    end
  end

  // Crossed level counts once the last two stages agree
  always_ff @(posedge link_sck or negedge reset_n) begin
    if (!reset_n) begin
      en_l <= sfre_pkg::RST_ENABLE;
      stat_l <= '{ready: sfre_pkg::RST_READY,
                  compare: sfre_pkg::RST_COMPARE};
    end else begin
      if (en_sync[2] == en_sync[1]) begin
        en_l <= en_sync[2];
      end
      if (stat_s3 == stat_s2) begin
        stat_l <= stat_s3;
      end
    end
  end

  // Status byte: ready, compare, density, reserved
  assign stat_byte = {stat_l.ready, stat_l.compare,
                      sfre_pkg::DENSITY_CODE,
                      sfre_pkg::STAT_RSVD};

  // Opcode decode and data start clock
  always_comb begin
    next_op = {op_sr[6:0], si};
    next_cmd = decode(next_op);
    case (next_cmd)
      sfre_pkg::SFRE_CMD_ARRAY, sfre_pkg::SFRE_CMD_PAGE: begin
        next_start = sfre_pkg::HDR_ARRAY;
      end
      sfre_pkg::SFRE_CMD_BUF1, sfre_pkg::SFRE_CMD_BUF2: begin
        next_start = sfre_pkg::HDR_BUF;
      end
      default: begin
        next_start = sfre_pkg::HDR_STATUS;
      end
    endcase
    // Inactive-polarity category starts data one clock later
    if (!next_op[sfre_pkg::OP_CAT_BIT]) begin
      next_start = 7'(next_start + sfre_pkg::LEGACY_EXTRA);
    end
  end

  // Serial clock counter since chip select fell
  always_ff @(posedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= '0;
    end else if (en_l && bit_cnt != sfre_pkg::CNT_MAX) begin
      bit_cnt <= 7'(bit_cnt + 7'h01);
    end
  end

  // Opcode and address shift registers
  always_ff @(posedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      op_sr <= '0;
      addr_sr <= '0;
    end else if (en_l) begin
      if (phase == sfre_pkg::SFRE_PH_OPCODE) begin
        op_sr <= next_op;
      end
      // Only the 24 clocks after the opcode land here
      if (phase == sfre_pkg::SFRE_PH_HEADER &&
          bit_cnt < sfre_pkg::ADDR_END) begin
        addr_sr <= {addr_sr[22:0], si};
      end
    end
  end

  // Command phase sequencer
  always_ff @(posedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase <= sfre_pkg::SFRE_PH_OPCODE;
      cmd <= sfre_pkg::SFRE_CMD_NONE;
      data_start <= sfre_pkg::HDR_STATUS;
    end else if (en_l) begin
      case (phase)
        sfre_pkg::SFRE_PH_OPCODE: begin
          if (bit_cnt == sfre_pkg::OPCODE_LAST) begin
            cmd <= next_cmd;
            data_start <= next_start;
            if (next_cmd == sfre_pkg::SFRE_CMD_NONE) begin
              phase <= sfre_pkg::SFRE_PH_IGNORE;
            end else if (7'(bit_cnt + 7'h01) == next_start) begin
              phase <= sfre_pkg::SFRE_PH_DATA;
            end else begin
              phase <= sfre_pkg::SFRE_PH_HEADER;
            end
          end
        end
        sfre_pkg::SFRE_PH_HEADER: begin
          // Dummy clocks only set up the read
          if (7'(bit_cnt + 7'h01) == data_start) begin
            phase <= sfre_pkg::SFRE_PH_DATA;
          end
        end
        sfre_pkg::SFRE_PH_DATA: begin
          phase <= sfre_pkg::SFRE_PH_DATA;
        end
        default: begin
          phase <= sfre_pkg::SFRE_PH_IGNORE;
        end
      endcase
    end
  end

  // Read pointer: loaded at data start, bit index stepped every clock, byte every eight
  always_ff @(posedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      page_ptr <= '0;
      byte_ptr <= '0;
      bit_idx <= sfre_pkg::BIT_FIRST;
    end else if (en_l) begin
      if (phase != sfre_pkg::SFRE_PH_DATA) begin
        // Reserved top four bits dropped
        page_ptr <= addr_sr[sfre_pkg::PAGE_LSB +: sfre_pkg::PAGE_W];
        byte_ptr <= addr_sr[sfre_pkg::BYTE_W-1:0];
        bit_idx <= sfre_pkg::BIT_FIRST;
      end else begin
        bit_idx <= 3'(bit_idx - 3'h1);
        if (bit_idx == '0) begin
          if (byte_ptr >= sfre_pkg::LAST_BYTE) begin
            byte_ptr <= '0;
            if (cmd == sfre_pkg::SFRE_CMD_ARRAY) begin
              if (page_ptr == sfre_pkg::LAST_PAGE) begin
                page_ptr <= '0;
              end else begin
                page_ptr <= 11'(page_ptr + 11'h001);
              end
            end
          end else begin
            byte_ptr <= 9'(byte_ptr + 9'h001);
          end
        end
      end
    end
  end

  // Status snapshot taken at the start of each status byte
  always_ff @(posedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      stat_shadow <= '0;
    end else if (en_l) begin
      if (phase != sfre_pkg::SFRE_PH_DATA || bit_idx == '0) begin
        stat_shadow <= stat_byte;
      end
    end
  end

  // Byte under the read pointer; reads never modify storage
  always_comb begin
    case (cmd)
      sfre_pkg::SFRE_CMD_ARRAY, sfre_pkg::SFRE_CMD_PAGE: begin
        cur_byte = in_range(byte_ptr) ?
                   main_mem[lin_addr(page_ptr, byte_ptr)] :
                   sfre_pkg::FILL_BYTE;
      end
      sfre_pkg::SFRE_CMD_BUF1: begin
        cur_byte = in_range(byte_ptr) ? buf1_mem[byte_ptr] :
                   sfre_pkg::FILL_BYTE;
      end
      sfre_pkg::SFRE_CMD_BUF2: begin
        cur_byte = in_range(byte_ptr) ? buf2_mem[byte_ptr] :
                   sfre_pkg::FILL_BYTE;
      end
      sfre_pkg::SFRE_CMD_STATUS: begin
        cur_byte = stat_shadow;
      end
      default: begin
        cur_byte = sfre_pkg::FILL_BYTE;
      end
    endcase
  end

  // Serial output launched on the falling edge
  always_ff @(negedge link_sck or negedge link_rst_n) begin
    if (!link_rst_n) begin
      so_data <= 1'b0;
      so_oe_n <= 1'b1;
    end else if (en_l) begin
      if (phase == sfre_pkg::SFRE_PH_DATA) begin
        so_data <= cur_byte[bit_idx];
        so_oe_n <= 1'b0;
      end else begin
        so_data <= 1'b0;
        so_oe_n <= 1'b1;
      end
    end
  end

endmodule

// ### core/sfre_pkg.sv
// Constants, types and carriers shared by the flash read engine
package sfre_pkg;

  // ---------------------------------------------------------------
  // Memory geometry
  // ---------------------------------------------------------------
  localparam int PAGE_BYTES = 264;
  localparam int PAGE_COUNT = 2048;
  localparam int ARRAY_BYTES = PAGE_BYTES * PAGE_COUNT;
  localparam int BUF_BYTES = 264;
  localparam int PAGE_W = 11;
  localparam int BYTE_W = 9;
  localparam int LIN_W = 20;
  localparam logic [BYTE_W-1:0] LAST_BYTE = 9'h107;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 11'h7FF;

  // ---------------------------------------------------------------
  // Opcodes: bit 7 set selects clock mode 0/3, clear selects
  // inactive-low/high clock polarity
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ARRAY_LEG = 8'h68;
  localparam logic [7:0] OP_ARRAY_SPI = 8'hE8;
  localparam logic [7:0] OP_PAGE_LEG = 8'h52;
  localparam logic [7:0] OP_PAGE_SPI = 8'hD2;
  localparam logic [7:0] OP_BUF1_LEG = 8'h54;
  localparam logic [7:0] OP_BUF1_SPI = 8'hD4;
  localparam logic [7:0] OP_BUF2_LEG = 8'h56;
  localparam logic [7:0] OP_BUF2_SPI = 8'hD6;
  localparam logic [7:0] OP_STAT_LEG = 8'h57;
  localparam logic [7:0] OP_STAT_SPI = 8'hD7;
  localparam int OP_CAT_BIT = 7;

  // ---------------------------------------------------------------
  // Frame layout, in serial clocks from the first opcode bit
  // ---------------------------------------------------------------
  localparam logic [6:0] OPCODE_LAST = 7'h07;
  localparam logic [6:0] ADDR_END = 7'h20;
  localparam logic [6:0] HDR_ARRAY = 7'h40;
  localparam logic [6:0] HDR_BUF = 7'h28;
  localparam logic [6:0] HDR_STATUS = 7'h08;
  localparam logic [6:0] LEGACY_EXTRA = 7'h01;
  localparam logic [6:0] CNT_MAX = 7'h7F;
  localparam int PAGE_LSB = 9;
  localparam logic [2:0] BIT_FIRST = 3'h7;

  // ---------------------------------------------------------------
  // Status byte and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] DENSITY_CODE = 3'h3;
  localparam logic [2:0] STAT_RSVD = 3'h0;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic RST_READY = 1'b0;
  localparam logic RST_COMPARE = 1'b0;
  localparam logic RST_ENABLE = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SFRE_CMD_NONE = 3'h0,
    SFRE_CMD_ARRAY = 3'h1,
    SFRE_CMD_PAGE = 3'h2,
    SFRE_CMD_BUF1 = 3'h3,
    SFRE_CMD_BUF2 = 3'h4,
    SFRE_CMD_STATUS = 3'h5
  } sfre_cmd_t;

  typedef enum logic [1:0] {
    SFRE_PH_OPCODE = 2'h0,
    SFRE_PH_HEADER = 2'h1,
    SFRE_PH_DATA = 2'h3,
    SFRE_PH_IGNORE = 2'h2
  } sfre_phase_t;

  typedef enum logic [1:0] {
    SFRE_TGT_ARRAY = 2'h0,
    SFRE_TGT_BUF1 = 2'h1,
    SFRE_TGT_BUF2 = 2'h2
  } sfre_target_t;

  typedef struct packed {
    logic valid;
    sfre_target_t target;
    logic [LIN_W-1:0] addr;
    logic [7:0] data;
  } sfre_load_t;

  typedef struct packed {
    logic ready;
    logic compare;
  } sfre_status_t;

endpackage

// ### sim/sfre_host.sv
// Host model that frames read commands on the serial link
`timescale 1ns/1ps
module sfre_host (
  output logic link_sck,
  output logic cs_n,
  output logic si,
  input wire logic so_data,
  input wire logic so_oe_n
);
  // ---------------------------------------------------------------
  // Idle link: clock low, deselected
  // ---------------------------------------------------------------
  initial begin
    link_sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end

  // One command frame, up to four data bytes gathered in rd
  task automatic frame(input logic [7:0] op, input logic [23:0] a,
      input int nby, output logic [31:0] rd, output logic oe_bad);
    int hdr;
    hdr = (op[3:0] == 4'h7) ? 8 : (op[2] ? 40 : 64);
    hdr = hdr + int'(!op[7]);
    rd = 32'h00000000;
    oe_bad = 1'b0;
    cs_n = 1'b0;
    #20;
    for (int i = 1; i <= hdr + 8 * nby; i++) begin
      // Opcode, address, then toggling filler bits
      si = (i <= 8) ? op[8-i] : ((i <= 32) ? a[32-i] : i[0]);
      #24 link_sck = 1'b1;
      if (i > hdr) begin
        // Floating line reads as the inverse of the last level
        rd = {rd[30:0], so_oe_n ? ~so_data : so_data};
        oe_bad = oe_bad | so_oe_n;
      end
      #24 link_sck = 1'b0;
      // Hold-off at each byte end, page ends included
      if (i > hdr && (i - hdr) % 8 == 0) #30;
    end
    #10 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// ### sim/sfre_engine_chk.sv
// Link timing checks for the flash read engine
`timescale 1ns/1ps
module sfre_engine_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire sfre_pkg::sfre_load_t load,
  input wire sfre_pkg::sfre_status_t status,
  input wire logic load_done,
  input wire logic link_sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic so_data,
  input wire logic so_oe_n
);
  logic [6:0] cnt;
  logic [7:0] op;
  logic [6:0] hdr;
  logic [2:0] pos;
  logic known;

  // Rising edges and opcode since chip select fell
  always_ff @(posedge link_sck or posedge cs_n or negedge reset_n) begin
    if (!reset_n || cs_n) begin
      cnt <= 7'h00;
      op <= 8'h00;
    end else begin
      if (cnt < 7'h7F) cnt <= cnt + 7'h01;
      if (cnt < 7'h08) op <= {op[6:0], si};
    end
  end

  // Header length of the captured opcode
  always_comb begin
    known = 1'b1;
    case (op[6:0])
      7'h68, 7'h52: hdr = 7'h40;
      7'h54, 7'h56: hdr = 7'h28;
      7'h57: hdr = 7'h08;
      default: begin
        hdr = 7'h7E;
        known = 1'b0;
      end
    endcase
    hdr = hdr + {6'h00, ~op[7]};
    pos = 3'(cnt - hdr);
  end

  sequence s_buf_last_quiet;
    (op[6:0] == 7'h54 || op[6:0] == 7'h56) && cnt == hdr - 7'h01;
  endsequence
  sequence s_stat_go;
    op[6:0] == 7'h57 && cnt == hdr;
  endsequence

  property p_float;
    @(posedge clock) disable iff (!reset_n) cs_n |-> so_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("output not floated while deselected");
  property p_quiet;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      known && cnt < hdr |-> so_oe_n;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("output driven during header");
  property p_arr_start;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      known && hdr[6] && cnt == hdr |-> !so_oe_n;
  endproperty
  a_arr_start: assert property (p_arr_start)
    else $error("array data not started after header");
  property p_buf_start;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      s_buf_last_quiet |-> so_oe_n ##1 !so_oe_n;
  endproperty
  a_buf_start: assert property (p_buf_start)
    else $error("buffer data start misplaced");
  property p_stat_start;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      s_stat_go |-> !so_oe_n ##1 !so_oe_n;
  endproperty
  a_stat_start: assert property (p_stat_start)
    else $error("status not driven after opcode");
  property p_dens_lo;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      op[6:0] == 7'h57 && cnt >= hdr && pos == 3'h2 |-> !so_data;
  endproperty
  a_dens_lo: assert property (p_dens_lo)
    else $error("status bit 5 wrong");
  property p_dens_hi;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      op[6:0] == 7'h57 && cnt >= hdr && pos inside {3'h3, 3'h4}
      |-> so_data;
  endproperty
  a_dens_hi: assert property (p_dens_hi)
    else $error("status bits 4 or 3 wrong");
  property p_refuse;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      !known && cnt >= 7'h08 |-> so_oe_n;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("output driven for unknown opcode");
  property p_hold;
    @(posedge link_sck) disable iff (!reset_n || cs_n)
      known && cnt > hdr |-> $stable(so_oe_n);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output enable dropped during data");
endmodule

bind sfre_engine sfre_engine_chk sfre_engine_chk_i (
  .clock(clock), .reset_n(reset_n), .clk_en(clk_en), .load(load),
  .status(status), .load_done(load_done), .link_sck(link_sck),
  .cs_n(cs_n), .si(si), .so_data(so_data), .so_oe_n(so_oe_n)
);

// ### sim/tb_top.sv
// Self-checking bench for the flash read engine
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
  cmp_count++; \
  if ((s) !== (e)) begin \
    errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); \
  end \
end
module tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  sfre_pkg::sfre_load_t load = '0;
  sfre_pkg::sfre_status_t status = '0;
  logic load_done;
  logic link_sck;
  logic cs_n;
  logic si;
  logic so_data;
  logic so_oe_n;
  int errors = 0;
  int cmp_count = 0;

  // ---------------------------------------------------------------
  // Clock, design and host
  // ---------------------------------------------------------------
  always #2.5 clock = ~clock;

  sfre_engine sfre_engine_i (.clock(clock), .reset_n(reset_n),
    .clk_en(clk_en), .load(load), .status(status),
    .load_done(load_done), .link_sck(link_sck), .cs_n(cs_n), .si(si),
    .so_data(so_data), .so_oe_n(so_oe_n));
  sfre_host sfre_host_i (.link_sck(link_sck), .cs_n(cs_n), .si(si),
    .so_data(so_data), .so_oe_n(so_oe_n));

  // One preload byte, acknowledged one cycle later
  task automatic ld(input logic [1:0] t, input logic [19:0] a,
      input logic [7:0] d);
    @(negedge clock);
    load = '{1'b1, sfre_pkg::sfre_target_t'(t), a, d};
    @(negedge clock);
    load.valid = 1'b0;
    `CHK("load_done", 1'b1, load_done)
  endtask

  // One read frame with expected data
  task automatic run(input logic [7:0] op, input logic [23:0] a,
      input int n, input logic [31:0] e);
    logic [31:0] r;
    logic bad;
    sfre_host_i.frame(op, a, n, r, bad);
    `CHK("data", e, r)
    `CHK("oe_n", 1'b0, bad)
    #5 `CHK("float", 1'b1, so_oe_n)
  endtask

  task automatic t_refuse();
    logic [31:0] r;
    logic bad;
    sfre_host_i.frame(8'h00, 24'h000000, 1, r, bad);
    `CHK("tri", 1'b1, bad)
    $display("test refuse done");
  endtask

  task automatic t_buffer();
    ld(2'h1, 20'h00107, 8'h6E);
    ld(2'h1, 20'h00000, 8'h5A);
    ld(2'h2, 20'h00004, 8'h77);
    run(8'hD4, 24'hFFFF07, 2, 32'h00006E5A);
    run(8'h54, 24'h000000, 1, 32'h0000005A);
    run(8'h56, 24'h000004, 1, 32'h00000077);
    run(8'hD6, 24'hFFFE04, 1, 32'h00000077);
    $display("test buffer done");
  endtask

  task automatic t_array();
    ld(2'h0, 20'h0062E, 8'hA1);
    ld(2'h0, 20'h0062F, 8'hB2);
    ld(2'h0, 20'h00630, 8'hC3);
    ld(2'h0, 20'h83FFF, 8'h3C);
    ld(2'h0, 20'h00000, 8'h4D);
    run(8'hE8, {4'hF, 11'h005, 9'h106}, 3, 32'h00A1B2C3);
    run(8'h68, {4'h0, 11'h7FF, 9'h107}, 2, 32'h00003C4D);
    $display("test array done");
  endtask

  task automatic t_page();
    ld(2'h0, 20'h00A4F, 8'h11);
    ld(2'h0, 20'h00948, 8'h22);
    ld(2'h0, 20'h00A50, 8'h99);
    run(8'hD2, {4'h0, 11'h009, 9'h107}, 2, 32'h00001122);
    run(8'h52, {4'hA, 11'h009, 9'h107}, 1, 32'h00000011);
    run(8'hD4, 24'h000000, 1, 32'h0000005A);
    $display("test page done");
  endtask

  task automatic t_status();
    logic [31:0] r;
    logic bad;
    @(negedge clock);
    status = '{1'b1, 1'b1};
    // Status drops during the first byte; later bytes show it
    fork
      sfre_host_i.frame(8'hD7, 24'h000000, 3, r, bad);
      #400 status = '{1'b0, 1'b0};
    join
    `CHK("stat_hi", 5'h1B, r[23:19])
    `CHK("stat_new", 5'h03, r[15:11])
    `CHK("density", 3'h3, r[5:3])
    `CHK("stat_oe", 1'b0, bad)
    @(negedge clock);
    status = '{1'b1, 1'b0};
    sfre_host_i.frame(8'h57, 24'h000000, 3, r, bad);
    `CHK("stat_lo", 5'h13, r[7:3])
    $display("test status done");
  endtask

  // Load made while the clock enable is low must not land
  task automatic t_freeze();
    ld(2'h2, 20'h00005, 8'h44);
    @(negedge clock);
    clk_en = 1'b0;
    load = '{1'b1, sfre_pkg::SFRE_TGT_BUF2, 20'h00005, 8'h33};
    repeat (2) @(negedge clock);
    `CHK("frozen_ack", 1'b0, load_done)
    load.valid = 1'b0;
    clk_en = 1'b1;
    run(8'hD6, 24'h000005, 1, 32'h00000044);
    $display("test freeze done");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #300000;
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    repeat (6) @(negedge clock);
    reset_n = 1'b1;
    t_refuse();
    t_buffer();
    t_array();
    t_page();
    t_freeze();
    t_status();
    close_out();
  end
endmodule
